// [rtl/position_counter_pkg.sv]
// Constants and carrier types for the dual quadrature position counter
// Overview of operation
// R1: Two independent 20-bit up/down counters accumulate transducer increments.
// R2: Subaddresses 0,2 select channel 0; subaddresses 1,3 select channel 1.
// R3: Phase discriminator on two quadrature inputs chooses count up or down.
// R4: Static setting selects 1, 2 or 4 counts per quadrature period.
// R5: Transfer copies live count into buffer without disturbing counting.
// R6: Transfer captures both channels into their buffers at the same moment.
// R7: Each transfer sets the affected channel's transfer flag.
// R8: External transfer input acts on its falling edge like the dataway command.
// R9: F28 at A0/A1 copies counter to buffer and sets transfer flag.
// R10: F0 at A0/A1 drives buffer onto R1-R20 with Q.
// R11: F16 at A0/A1 loads counter from W1-W20 with Q.
// R12: Overrange flag sets when counter steps above maximum or below zero.
// R13: Transfer and overrange flags are four individually maskable request sources.
// R14: F17 A0 loads 4-bit enable from W1-W4 with Q.
// R15: F8 A0/A1 gives Q when transfer flag set and enabled.
// R16: F10 A0/A1 tests like F8 then clears the transfer flag.
// R17: F8 A2/A3 gives Q when overrange flag set and enabled.
// R18: F10 A2/A3 tests overrange then clears the overrange flag.
// R19: Initialise Z clears flags, counters and the request enable register.
// R20: Clear C zeroes both counters.
// R21: Counter wraps modulo 2^20 while raising the overrange flag.
// R22: Look-at-me asserts whenever any enabled flag is set.
package position_counter_pkg;
   localparam int          COUNT_WIDTH   = 20;
   localparam int          MASK_WIDTH    = 4;
   localparam logic [19:0] COUNT_RESET   = 20'h00000;
   localparam logic [19:0] COUNT_MAX     = 20'hfffff;
   localparam logic [3:0]  MASK_RESET    = 4'h0;
   // Enable mask bit positions
   localparam int          EN_XFER0      = 0;
   localparam int          EN_XFER1      = 1;
   localparam int          EN_OVR0       = 2;
   localparam int          EN_OVR1       = 3;
   // Function codes
   localparam logic [4:0]  FN_READ       = 5'h00;
   localparam logic [4:0]  FN_TEST       = 5'h08;
   localparam logic [4:0]  FN_TEST_CLEAR = 5'h0a;
   localparam logic [4:0]  FN_PRELOAD    = 5'h10;
   localparam logic [4:0]  FN_MASK       = 5'h11;
   localparam logic [4:0]  FN_TRANSFER   = 5'h1c;
   // Counts per period encodings
   localparam logic [1:0]  MULT_X1       = 2'h0;
   localparam logic [1:0]  MULT_X2       = 2'h1;
   localparam logic [1:0]  MULT_X4       = 2'h2;

   typedef struct packed {
      logic        strobe;
      logic [4:0]  func;
      logic [3:0]  subaddr;
      logic [19:0] wdata;
   } dataway_cmd_t;

   typedef struct packed {
      logic        q;
      logic        x;
      logic [19:0] rdata;
   } dataway_resp_t;
endpackage : position_counter_pkg

// [rtl/dual_quadrature_position_counter.sv]
// Dual 20-bit quadrature position counter with dataway command decode
`timescale 1ns/1ns
module dual_quadrature_position_counter (
   input  wire logic                               clock,
   input  wire logic                               reset_n,
   input  wire position_counter_pkg::dataway_cmd_t cmd,
   input  wire logic                               init_z,
   input  wire logic                               clear_c,
   input  wire logic [1:0]                         counts_per_period,
   input  wire logic [1:0]                         phase_a,
   input  wire logic [1:0]                         phase_b,
   input  wire logic [1:0]                         transfer_n,
   output      position_counter_pkg::dataway_resp_t resp,
   output      logic                               look_at_me
);

   // ----------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------
   logic [1:0] a_s1, a_s2, a_s3, b_s1, b_s2, b_s3, t_s1, t_s2, t_s3;
   logic [1:0] a_st, b_st, t_st;

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         {a_s1, a_s2, a_s3} <= '0;
         {b_s1, b_s2, b_s3} <= '0;
         {t_s1, t_s2, t_s3} <= 6'h3f;
      end else begin
         a_s1 <= phase_a;
         a_s2 <= a_s1;
         a_s3 <= a_s2;
         b_s1 <= phase_b;
         b_s2 <= b_s1;
         b_s3 <= b_s2;
         t_s1 <= transfer_n;
         t_s2 <= t_s1;
         t_s3 <= t_s2;
      end
   end

   // Accepted levels move only when stages two and three agree
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         a_st <= '0;
         b_st <= '0;
         t_st <= 2'h3;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (a_s2[i] == a_s3[i]) a_st[i] <= a_s3[i];
            if (b_s2[i] == b_s3[i]) b_st[i] <= b_s3[i];
            if (t_s2[i] == t_s3[i]) t_st[i] <= t_s3[i];
         end
      end
   end

   // ----------------------------------------------------------
   // Phase discriminator
   // ----------------------------------------------------------
   logic [1:0] a_prev, b_prev, t_prev;
   logic [1:0] step_en, step_up;

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         a_prev <= '0;
         b_prev <= '0;
         t_prev <= 2'h3;
      end else begin
         a_prev <= a_st;
         b_prev <= b_st;
         t_prev <= t_st;
      end
   end

   // ----------------------------------------------------------
   // Edge and direction decode
   // ----------------------------------------------------------
   logic [1:0] a_edge;
   logic [1:0] b_edge;
   logic [1:0] t_fall;

   assign a_edge  = a_st ^ a_prev;
   assign b_edge  = b_st ^ b_prev;
   // Forward when the new B level differs from the previous A level
   assign step_up = a_prev ^ b_st; // R3
   // Transfer pins act on the falling edge only
   assign t_fall  = t_prev & ~t_st; // R8

   // Both phases moving in one cycle is a lost step; dropped rather than guessed
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         unique case (counts_per_period) // R4
            position_counter_pkg::MULT_X1: begin
               step_en[i] = a_edge[i] && a_st[i] && !b_edge[i];
            end
            position_counter_pkg::MULT_X2: begin
               step_en[i] = a_edge[i] && !b_edge[i];
            end
            position_counter_pkg::MULT_X4: begin
               step_en[i] = a_edge[i] ^ b_edge[i];
            end
            default: begin
               step_en[i] = 1'b0;
            end
         endcase
      end
   end

   // ----------------------------------------------------------
   // Dataway command decode
   // ----------------------------------------------------------
   // Strobe carries this function at or below the highest legal subaddress
   function automatic logic fn_hit(
      input position_counter_pkg::dataway_cmd_t c,
      input logic [4:0]                         code,
      input logic [3:0]                         top_sub
   );
      return c.strobe && (c.func == code) && (c.subaddr <= top_sub);
   endfunction : fn_hit

   // Subaddress bit 0 names the channel
   function automatic logic chan_is(
      input logic s,
      input int   i
   );
      return s == 1'(i);
   endfunction : chan_is

   logic cmd_read;
   logic cmd_preload;
   logic cmd_transfer;
   logic cmd_mask;
   logic cmd_test;
   logic cmd_test_clear;
   logic sel;
   logic flag_bank;

   assign cmd_read       = fn_hit(cmd, position_counter_pkg::FN_READ, 4'h1);       // R10
   assign cmd_preload    = fn_hit(cmd, position_counter_pkg::FN_PRELOAD, 4'h1);    // R11
   assign cmd_transfer   = fn_hit(cmd, position_counter_pkg::FN_TRANSFER, 4'h1);   // R9
   assign cmd_mask       = fn_hit(cmd, position_counter_pkg::FN_MASK, 4'h0);       // R14
   assign cmd_test       = fn_hit(cmd, position_counter_pkg::FN_TEST, 4'h3);       // R15
   assign cmd_test_clear = fn_hit(cmd, position_counter_pkg::FN_TEST_CLEAR, 4'h3); // R16
   // Bit 0 picks the channel, bit 1 the overrange flag bank
   assign sel            = cmd.subaddr[0]; // R2
   assign flag_bank      = cmd.subaddr[1]; // R2

   // ----------------------------------------------------------
   // Per-channel control
   // ----------------------------------------------------------
   logic [1:0][19:0] count;
   logic [1:0][19:0] snapshot;
   logic [3:0]       request_enable_mask;
   logic [1:0]       preload_hit;
   logic [1:0]       step_go;
   logic [1:0]       wrap;
   logic [1:0]       xfer_set;
   logic [1:0]       clear_xfer;
   logic [1:0]       clear_ovr;
   logic [1:0]       xfer_flag;
   logic [1:0]       ovr_flag;

   always_comb begin
      for (int i = 0; i < 2; i++) begin
         preload_hit[i] = cmd_preload && chan_is(sel, i);
         // Load and clear own the cycle; a step arriving then is lost
         step_go[i]     = step_en[i] && !preload_hit[i] && !clear_c;
         wrap[i]        = step_go[i] && (step_up[i] ? (count[i] == position_counter_pkg::COUNT_MAX) :
                                                      (count[i] == position_counter_pkg::COUNT_RESET)); // R12
         // Pin or command refreshes both buffers but flags only its own channel
         xfer_set[i]    = t_fall[i] || (cmd_transfer && chan_is(sel, i)); // R7
         clear_xfer[i]  = cmd_test_clear && !flag_bank && chan_is(sel, i); // R16
         clear_ovr[i]   = cmd_test_clear && flag_bank && chan_is(sel, i); // R18
      end
   end

   // ----------------------------------------------------------
   // Counters
   // ----------------------------------------------------------
   always_ff @(posedge clock) begin
      if (!reset_n || init_z || clear_c) begin // R19 R20
         count <= {2{position_counter_pkg::COUNT_RESET}};
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (preload_hit[i]) begin
               count[i] <= cmd.wdata; // R11
            end else if (step_go[i]) begin
               // Plain 20-bit arithmetic wraps at both ends
               count[i] <= step_up[i] ? count[i] + 20'h00001 : count[i] - 20'h00001; // R1 R21
            end
         end
      end
   end

   // ----------------------------------------------------------
   // Snapshot buffers
   // ----------------------------------------------------------
   // Counters keep running; the buffers only sample them
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         snapshot <= {2{position_counter_pkg::COUNT_RESET}};
      end else if (|xfer_set) begin
         snapshot <= count; // R5 R6
      end
   end

   // ----------------------------------------------------------
   // Flags and request enables
   // ----------------------------------------------------------
   // A new event beats a clear in the same cycle so no reading is lost
   always_ff @(posedge clock) begin
      if (!reset_n || init_z) begin // R19
         xfer_flag <= '0;
         ovr_flag  <= '0;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (xfer_set[i]) begin
               xfer_flag[i] <= 1'b1; // R7
            end else if (clear_xfer[i]) begin
               xfer_flag[i] <= 1'b0; // R16
            end
            if (wrap[i]) begin
               ovr_flag[i] <= 1'b1; // R12
            end else if (clear_ovr[i]) begin
               ovr_flag[i] <= 1'b0; // R18
            end
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!reset_n || init_z) begin // R19
         request_enable_mask <= position_counter_pkg::MASK_RESET;
      end else if (cmd_mask) begin
         request_enable_mask <= cmd.wdata[3:0]; // R14
      end
   end

   // ----------------------------------------------------------
   // Look-at-me and Q test
   // ----------------------------------------------------------
   logic [3:0]  pending;
   logic        pending_any;
   logic        test_q;
   logic [19:0] read_word;

   // Bit order follows the enable register: xfer0, xfer1, ovr0, ovr1
   assign pending     = {ovr_flag[1], ovr_flag[0], xfer_flag[1], xfer_flag[0]} & request_enable_mask; // R13
   assign pending_any = |pending;
   assign test_q      = flag_bank ?
                        pending[position_counter_pkg::EN_OVR0 + sel] :
                        pending[position_counter_pkg::EN_XFER0 + sel]; // R15 R17
   assign read_word   = snapshot[sel];

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         look_at_me <= 1'b0;
      end else begin
         look_at_me <= pending_any; // R22
      end
   end

   // ----------------------------------------------------------
   // Dataway response
   // ----------------------------------------------------------
   // Q and data stand for the one cycle after the strobe is taken
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         resp <= '0;
      end else begin
         resp <= '0;
         if (cmd_read) begin
            resp.q     <= 1'b1; // R10
            resp.x     <= 1'b1;
            resp.rdata <= read_word;
         end
         if (cmd_preload || cmd_mask || cmd_transfer) begin
            resp.q <= 1'b1; // R11 R14 R9
            resp.x <= 1'b1;
         end
         if (cmd_test || cmd_test_clear) begin
            resp.q <= test_q; // R15 R16 R17 R18
            resp.x <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------
   property p_lam_follows;
      @(posedge clock) disable iff (!reset_n) $past(reset_n) |-> (look_at_me == $past(pending_any));
   endproperty
   a_lam_follows: assert property (p_lam_follows) // R22
      else $error("look-at-me does not follow the enabled flags");
   property p_ovr_on_wrap;
      @(posedge clock) disable iff (!reset_n) (wrap != 2'h0) && !init_z |=> ((ovr_flag & $past(wrap)) == $past(wrap));
   endproperty
   a_ovr_on_wrap: assert property (p_ovr_on_wrap) // R12
      else $error("overrange flag not set on wrap");
   property p_wrap_up_zero;
      @(posedge clock) disable iff (!reset_n) wrap[0] && step_up[0] |=> (count[0] == position_counter_pkg::COUNT_RESET);
   endproperty
   a_wrap_up_zero: assert property (p_wrap_up_zero) // R21
      else $error("channel 0 did not wrap to zero");
   property p_wrap_down_max;
      @(posedge clock) disable iff (!reset_n) wrap[1] && !step_up[1] && !init_z |=> (count[1] == position_counter_pkg::COUNT_MAX);
   endproperty
   a_wrap_down_max: assert property (p_wrap_down_max) // R21
      else $error("channel 1 did not wrap to full scale");
   property p_snapshot_capture;
      @(posedge clock) disable iff (!reset_n) (xfer_set != 2'h0) |=> (snapshot == $past(count));
   endproperty
   a_snapshot_capture: assert property (p_snapshot_capture) // R6
      else $error("buffers do not hold the counts of the transfer cycle");
   property p_read_answer;
      @(posedge clock) disable iff (!reset_n) cmd_read |=> resp.q && resp.x && (resp.rdata == $past(read_word));
   endproperty
   a_read_answer: assert property (p_read_answer) // R10
      else $error("read answer wrong");
   property p_init_clears;
      @(posedge clock) disable iff (!reset_n) init_z |=> (count == {2{position_counter_pkg::COUNT_RESET}}) &&
         (xfer_flag == 2'h0) && (ovr_flag == 2'h0) && (request_enable_mask == position_counter_pkg::MASK_RESET);
   endproperty
   a_init_clears: assert property (p_init_clears) // R19
      else $error("initialise left state behind");
   property p_clear_zeroes;
      @(posedge clock) disable iff (!reset_n) clear_c |=> (count == {2{position_counter_pkg::COUNT_RESET}});
   endproperty
   a_clear_zeroes: assert property (p_clear_zeroes) // R20
      else $error("clear left a counter nonzero");
endmodule : dual_quadrature_position_counter

// [sim/transducer_model.sv]
// Quadrature source, one phase edge per clock while run is high
`timescale 1ns/1ns
module transducer_model (
   input  wire logic       clock,
   input  wire logic [1:0] run,
   output logic      [1:0] phase_a,
   output logic      [1:0] phase_b
);
   logic [3:0] pos = 4'h0;
   always_ff @(posedge clock) begin
      if (run[0]) pos[1:0] <= pos[1:0] + 2'h1;
      if (run[1]) pos[3:2] <= pos[3:2] + 2'h1;
   end
   assign phase_a = {pos[3], pos[1]};
   assign phase_b = {pos[3] ^ pos[2], pos[1] ^ pos[0]};
endmodule : transducer_model

// [sim/tb_dual_quadrature_position_counter.sv]
// Self-checking bench for the dual quadrature position counter
`timescale 1ns/1ns
module tb_dual_quadrature_position_counter;
   logic                                clock = 0, reset_n = 0, init_z = 0, clear_c = 0, look_at_me, up;
   logic [1:0]                          run = 0, transfer_n = 2'h3, phase_a, phase_b;
   logic [20:0]                         got;
   position_counter_pkg::dataway_cmd_t  cmd = '0;
   position_counter_pkg::dataway_resp_t resp;
   int                                  err_total = 0, checks = 0;
   localparam logic [20:0] Q = 21'h100000;
   dual_quadrature_position_counter dut (.clock(clock), .reset_n(reset_n), .cmd(cmd), .init_z(init_z),
      .clear_c(clear_c), .counts_per_period(position_counter_pkg::MULT_X4), .phase_a(phase_a),
      .phase_b(phase_b), .transfer_n(transfer_n), .resp(resp), .look_at_me(look_at_me));
   transducer_model model (.clock(clock), .run(run), .phase_a(phase_a), .phase_b(phase_b));
   initial forever #4 clock = ~clock;
   task automatic dw(input logic [4:0] f, input logic [3:0] a, input logic [19:0] w);
      @(posedge clock) cmd <= '{1'b1, f, a, w};
      @(posedge clock) cmd <= '0;
      @(negedge clock) got = {resp.q, resp.rdata};
      repeat (3) @(posedge clock);
   endtask : dw
   task automatic cmp(input logic [20:0] exp, input logic [20:0] msk);
      checks++;
      if ((got & msk) !== exp) begin
         err_total++;
         $display("mismatch at %0t: got %h expected %h", $time, got & msk, exp);
      end
   endtask : cmp
   task automatic close_out;
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : close_out
   initial begin
      #100000 err_total++;
      close_out();
   end
   initial begin
      repeat (5) @(posedge clock);
      reset_n <= 1;
      @(posedge clock) init_z <= 1;
      @(posedge clock) init_z <= 0;
      dw(position_counter_pkg::FN_MASK, 0, 20'h0000f); cmp(Q, Q);
      dw(position_counter_pkg::FN_PRELOAD, 0, position_counter_pkg::COUNT_MAX); cmp(Q, Q);
      dw(position_counter_pkg::FN_PRELOAD, 1, 20'h00000);
      @(posedge clock) run <= 2'h3;
      @(posedge clock) run <= 2'h0;
      repeat (8) @(posedge clock);
      dw(position_counter_pkg::FN_TRANSFER, 0, 0); cmp(Q, Q);
      dw(position_counter_pkg::FN_READ, 0, 0);
      up = (got[19:0] == 20'h00000);
      cmp(up ? Q : Q | 21'hffffe, 21'h1fffff);
      dw(position_counter_pkg::FN_READ, 1, 0); cmp(up ? Q | 21'h1 : Q | 21'hfffff, 21'h1fffff);
      dw(position_counter_pkg::FN_TEST, up ? 4'h2 : 4'h3, 0); cmp(Q, Q);
      dw(position_counter_pkg::FN_TEST, up ? 4'h3 : 4'h2, 0); cmp(21'h0, Q);
      dw(position_counter_pkg::FN_TEST_CLEAR, up ? 4'h2 : 4'h3, 0); cmp(Q, Q);
      dw(position_counter_pkg::FN_TEST, up ? 4'h2 : 4'h3, 0); cmp(21'h0, Q);
      dw(position_counter_pkg::FN_TEST, 0, 0); cmp(Q, Q);
      got = {look_at_me, 20'h0}; cmp(Q, Q);
      dw(position_counter_pkg::FN_TEST_CLEAR, 0, 0); cmp(Q, Q);
      dw(position_counter_pkg::FN_TEST, 0, 0); cmp(21'h0, Q);
      got = {look_at_me, 20'h0}; cmp(21'h0, Q);
      @(posedge clock) transfer_n <= 2'h1;
      repeat (8) @(posedge clock);
      transfer_n <= 2'h3;
      repeat (8) @(posedge clock);
      dw(position_counter_pkg::FN_TEST, 1, 0); cmp(Q, Q);
      @(posedge clock) clear_c <= 1;
      @(posedge clock) clear_c <= 0;
      dw(position_counter_pkg::FN_TRANSFER, 1, 0);
      dw(position_counter_pkg::FN_READ, 1, 0); cmp(Q, 21'h1fffff);
      $display("dataway sequence done");
      close_out();
   end
endmodule : tb_dual_quadrature_position_counter
